// ### adcc_control.sv
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
// Notes on behaviour
// - sample time code picks 4..768 cycles; codes 12-15 give 1024 cycles
// - multi-sample clear: every sample-and-convert needs a new rising sample input edge
// - multi-sample set: first edge starts, later samples follow each finished conversion
// - multi-sample has no effect in single-channel single-conversion mode
// - sample time, multi-sample and power-on writable only while enable is zero
// - locked fields changed after enable clears act at once, even mid conversion
// - writing one to software start requests a conversion; bit clears itself
// - enable and software start may be set in one write
// - reserved bits of control zero read zero and ignore writes
// - source select 00 picks software start, other codes pick timer triggers
module adcc_control
  import adcc_pkg::*;
(
  // clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_nrst,
  // register port
  input  wire logic [4:0]  i_addr,
  input  wire logic [15:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [15:0] o_rdata,
  // timer trigger pins
  input  wire logic [2:0]  i_timer_trig,
  // converter core
  input  wire logic        i_conv_done,
  input  wire logic [9:0]  i_conv_result,
  output wire logic        o_sample_hold,
  output logic             o_convert_start,
  output wire logic        o_converter_on,
  output wire logic        o_busy
);

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [3:0]  sample_time_select;
  logic        multi_sample_auto;
  logic        converter_power_on;
  logic        conversion_enable_lock;
  logic        software_start;
  logic [10:0] ctl1_cfg;
  logic [15:0] ctl2;
  logic [15:0] win_lo;
  logic [15:0] win_hi;
  logic [15:0] mctl;
  logic [15:0] result;
  logic [15:0] int_en;
  logic [15:0] int_flags;
  logic [15:0] int_vec;
  adcc_state_t state;
  adcc_state_t next_state;
  logic        next_convert_start;
  logic        trig_edge;

  adcc_timer_if tmr ();

  ////////////////////////////////////////////////////////////////////////////
  // decode
  wire sel_ctl0   = (i_addr == ADCC_OFS_CTL0);
  wire sel_ctl1   = (i_addr == ADCC_OFS_CTL1);
  wire wr_ctl0    = i_wr && sel_ctl0;
  wire wr_ctl1    = i_wr && sel_ctl1;
  wire unlocked   = !conversion_enable_lock;
  wire wr_locked0 = wr_ctl0 && unlocked;
  wire next_enc   = wr_ctl0 ? i_wdata[ADCC_ENC_POS] : conversion_enable_lock;
  wire next_on    = wr_locked0 ? i_wdata[ADCC_ON_POS] : converter_power_on;
  wire sc_req     = wr_ctl0 && i_wdata[ADCC_SC_POS] && next_enc && next_on;
  wire [1:0] source_select = ctl1_cfg[ADCC_SHS_LSB-ADCC_CFG1_LSB +: 2];
  wire [1:0] conseq        = ctl1_cfg[ADCC_CONSEQ_LSB-ADCC_CFG1_LSB +: 2];
  wire seq_mode   = (conseq != 2'b00);
  wire msc_eff    = multi_sample_auto && seq_mode;
  wire run_ok     = conversion_enable_lock && converter_power_on;
  wire busy       = (state != ADCC_IDLE);
  wire auto_next  = i_conv_done && msc_eff && run_ok;

  wire [15:0] ctl0_view = {4'h0, sample_time_select, multi_sample_auto, 2'b00,
                           converter_power_on, 2'b00, conversion_enable_lock,
                           software_start};
  wire [15:0] ctl1_view = {4'h0, ctl1_cfg, busy};

  ////////////////////////////////////////////////////////////////////////////
  // register writes
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      sample_time_select     <= ADCC_RST_CTL0[ADCC_SHT_LSB +: 4];
      multi_sample_auto      <= ADCC_RST_CTL0[ADCC_MSC_POS];
      converter_power_on     <= ADCC_RST_CTL0[ADCC_ON_POS];
      conversion_enable_lock <= ADCC_RST_CTL0[ADCC_ENC_POS];
      software_start         <= ADCC_RST_CTL0[ADCC_SC_POS];
    end else begin
      software_start         <= sc_req;
      conversion_enable_lock <= next_enc;
      converter_power_on     <= next_on;
      if (wr_locked0) begin
        sample_time_select <= i_wdata[ADCC_SHT_LSB +: 4];
        multi_sample_auto  <= i_wdata[ADCC_MSC_POS];
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      ctl1_cfg <= ADCC_RST_CTL1[ADCC_CFG1_LSB +: 11];
    end else if (wr_ctl1 && unlocked) begin
      ctl1_cfg <= i_wdata[ADCC_CFG1_LSB +: 11];
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      ctl2      <= ADCC_RST_CTL2;
      win_lo    <= ADCC_RST_WIN_LO;
      win_hi    <= ADCC_RST_WIN_HI;
      mctl      <= ADCC_RST_MCTL;
      int_en    <= ADCC_RST_IE;
      int_flags <= ADCC_RST_IFG;
      int_vec   <= ADCC_RST_IV;
    end else if (i_wr) begin
      case (i_addr)
        ADCC_OFS_CTL2:   ctl2      <= i_wdata;
        ADCC_OFS_WIN_LO: win_lo    <= i_wdata;
        ADCC_OFS_WIN_HI: win_hi    <= i_wdata;
        ADCC_OFS_MCTL:   mctl      <= i_wdata;
        ADCC_OFS_IE:     int_en    <= i_wdata;
        ADCC_OFS_IFG:    int_flags <= i_wdata;
        ADCC_OFS_IV:     int_vec   <= i_wdata;
        default: begin
        end
      endcase
    end
  end

  // a finished conversion wins over a software write in the same cycle
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      result <= ADCC_RST_RESULT;
    end else if (i_conv_done) begin
      result <= {6'h00, i_conv_result};
    end else if (i_wr && i_addr == ADCC_OFS_RESULT) begin
      result <= i_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port: data valid only in the cycle after the strobe
  logic [15:0] rd_mux;
  always_comb begin
    case (i_addr)
      ADCC_OFS_CTL0:   rd_mux = ctl0_view;
      ADCC_OFS_CTL1:   rd_mux = ctl1_view;
      ADCC_OFS_CTL2:   rd_mux = ctl2;
      ADCC_OFS_WIN_LO: rd_mux = win_lo;
      ADCC_OFS_WIN_HI: rd_mux = win_hi;
      ADCC_OFS_MCTL:   rd_mux = mctl;
      ADCC_OFS_RESULT: rd_mux = result;
      ADCC_OFS_IE:     rd_mux = int_en;
      ADCC_OFS_IFG:    rd_mux = int_flags;
      ADCC_OFS_IV:     rd_mux = int_vec;
      default:         rd_mux = 16'h0000;
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rdata <= 16'h0000;
    end else begin
      o_rdata <= i_rd ? rd_mux : 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // trigger and sampling timer
  adcc_trigger u_trigger (
    .i_clk_sys    (i_clk_sys),
    .i_nrst       (i_nrst),
    .i_timer_trig (i_timer_trig),
    .i_sw_start   (software_start),
    .i_sel        (source_select),
    .o_edge       (trig_edge)
  );

  adcc_sample_timer u_timer (
    .i_clk_sys (i_clk_sys),
    .i_nrst    (i_nrst),
    .tmr       (tmr.timer)
  );

  wire edge_start = (state == ADCC_IDLE) && trig_edge && run_ok;
  assign tmr.start = edge_start || ((state == ADCC_CONVERT) && auto_next);
  assign tmr.stop  = !converter_power_on;
  assign tmr.code  = sample_time_select;

  ////////////////////////////////////////////////////////////////////////////
  // sequencing
  always_comb begin
    next_state         = state;
    next_convert_start = 1'b0;
    case (state)
      ADCC_IDLE: begin
        if (edge_start) begin
          next_state = ADCC_SAMPLE;
        end
      end
      ADCC_SAMPLE: begin
        if (tmr.done) begin
          next_state         = ADCC_CONVERT;
          next_convert_start = 1'b1;
        end
      end
      ADCC_CONVERT: begin
        if (i_conv_done) begin
          next_state = auto_next ? ADCC_SAMPLE : ADCC_IDLE;
        end
      end
      default: next_state = ADCC_IDLE;
    endcase
    if (!converter_power_on) begin
      next_state         = ADCC_IDLE;
      next_convert_start = 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      state           <= ADCC_IDLE;
      o_convert_start <= 1'b0;
    end else begin
      state           <= next_state;
      o_convert_start <= next_convert_start;
    end
  end

  assign o_sample_hold  = tmr.active;
  assign o_converter_on = converter_power_on;
  assign o_busy         = busy;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);

  property p_lock_hold;
    wr_ctl0 && conversion_enable_lock |=>
      sample_time_select == $past(sample_time_select) &&
      multi_sample_auto == $past(multi_sample_auto);
  endproperty
  a_lock_hold : assert property (p_lock_hold) else $error("locked field changed");

  property p_unlocked_write;
    wr_ctl0 && !conversion_enable_lock |=>
      sample_time_select == $past(i_wdata[ADCC_SHT_LSB +: 4]);
  endproperty
  a_unlocked_write : assert property (p_unlocked_write) else $error("field not written");

  property p_sc_self_clear;
    software_start |=> !software_start [*1] or (software_start && $past(sc_req));
  endproperty
  a_sc_self_clear : assert property (p_sc_self_clear) else $error("start bit stuck");

  property p_one_write_start;
    wr_ctl0 && i_wdata[ADCC_ENC_POS] && i_wdata[ADCC_SC_POS] && next_on
      |=> software_start && conversion_enable_lock;
  endproperty
  a_one_write_start : assert property (p_one_write_start) else $error("combined start lost");

  property p_reserved_zero;
    i_rd && sel_ctl0 |=> o_rdata[15:12] == 4'h0 && o_rdata[6:5] == 2'b00 &&
      o_rdata[3:2] == 2'b00;
  endproperty
  a_reserved_zero : assert property (p_reserved_zero) else $error("reserved bits set");

  property p_start_gated;
    wr_ctl0 && i_wdata[ADCC_SC_POS] && !(next_enc && next_on) |=> !software_start;
  endproperty
  a_start_gated : assert property (p_start_gated) else $error("start taken while off");

  property p_edge_only;
    state == ADCC_IDLE && !trig_edge |=> state == ADCC_IDLE;
  endproperty
  a_edge_only : assert property (p_edge_only) else $error("sample without edge");

  property p_auto_restart;
    state == ADCC_CONVERT && auto_next |=> state == ADCC_SAMPLE ##1 o_sample_hold;
  endproperty
  a_auto_restart : assert property (p_auto_restart) else $error("no automatic restart");

  property p_single_stops;
    state == ADCC_CONVERT && i_conv_done && !seq_mode |=> state == ADCC_IDLE;
  endproperty
  a_single_stops : assert property (p_single_stops) else $error("single mode repeated");

  property p_source_sw;
    source_select == 2'b00 && $past(source_select) == 2'b00 && !software_start
      && !$past(software_start) |-> !trig_edge;
  endproperty
  a_source_sw : assert property (p_source_sw) else $error("timer pin used as source");

  c_single_conv : cover property (state == ADCC_CONVERT && i_conv_done && !seq_mode);
  c_auto_seq    : cover property (state == ADCC_CONVERT && auto_next);
  c_timer_src   : cover property (trig_edge && source_select != 2'b00 && run_ok);

endmodule

// ### adcc_pkg.sv
package adcc_pkg;

  localparam int unsigned ADCC_CLK_MHZ = 200;

  // register offsets
  localparam logic [4:0] ADCC_OFS_CTL0   = 5'h00;
  localparam logic [4:0] ADCC_OFS_CTL1   = 5'h02;
  localparam logic [4:0] ADCC_OFS_CTL2   = 5'h04;
  localparam logic [4:0] ADCC_OFS_WIN_LO = 5'h06;
  localparam logic [4:0] ADCC_OFS_WIN_HI = 5'h08;
  localparam logic [4:0] ADCC_OFS_MCTL   = 5'h0a;
  localparam logic [4:0] ADCC_OFS_RESULT = 5'h12;
  localparam logic [4:0] ADCC_OFS_IE     = 5'h1a;
  localparam logic [4:0] ADCC_OFS_IFG    = 5'h1c;
  localparam logic [4:0] ADCC_OFS_IV     = 5'h1e;

  // converter_control_zero fields
  localparam int ADCC_SHT_LSB = 8;
  localparam int ADCC_MSC_POS = 7;
  localparam int ADCC_ON_POS  = 4;
  localparam int ADCC_ENC_POS = 1;
  localparam int ADCC_SC_POS  = 0;

  // converter_control_one fields
  localparam int ADCC_SHS_LSB    = 10;
  localparam int ADCC_CFG1_LSB   = 1;
  localparam int ADCC_CONSEQ_LSB = 1;
  localparam int ADCC_BUSY_POS   = 0;

  // reset values
  localparam logic [15:0] ADCC_RST_CTL0   = 16'h0000;
  localparam logic [15:0] ADCC_RST_CTL1   = 16'h0000;
  localparam logic [15:0] ADCC_RST_CTL2   = 16'h1000;
  localparam logic [15:0] ADCC_RST_WIN_LO = 16'h0000;
  localparam logic [15:0] ADCC_RST_WIN_HI = 16'hff03;
  localparam logic [15:0] ADCC_RST_MCTL   = 16'h0000;
  localparam logic [15:0] ADCC_RST_RESULT = 16'h0000;
  localparam logic [15:0] ADCC_RST_IE     = 16'h0000;
  localparam logic [15:0] ADCC_RST_IFG    = 16'h0000;
  localparam logic [15:0] ADCC_RST_IV     = 16'h0000;

  typedef enum logic [1:0] {ADCC_IDLE, ADCC_SAMPLE, ADCC_CONVERT} adcc_state_t;

  // sampling period in i_clk_sys cycles per sample_time_select code
  function automatic logic [10:0] adcc_sample_cycles(input logic [3:0] code);
    case (code)
      4'h0:    adcc_sample_cycles = 11'd4;
      4'h1:    adcc_sample_cycles = 11'd8;
      4'h2:    adcc_sample_cycles = 11'd16;
      4'h3:    adcc_sample_cycles = 11'd32;
      4'h4:    adcc_sample_cycles = 11'd64;
      4'h5:    adcc_sample_cycles = 11'd96;
      4'h6:    adcc_sample_cycles = 11'd128;
      4'h7:    adcc_sample_cycles = 11'd192;
      4'h8:    adcc_sample_cycles = 11'd256;
      4'h9:    adcc_sample_cycles = 11'd384;
      4'ha:    adcc_sample_cycles = 11'd512;
      4'hb:    adcc_sample_cycles = 11'd768;
      default: adcc_sample_cycles = 11'd1024;
    endcase
  endfunction

endpackage

// ### adcc_sample_timer.sv
`timescale 1ns/1ps
module adcc_sample_timer
  import adcc_pkg::*;
(
  // clock and reset
  input  wire logic  i_clk_sys,
  input  wire logic  i_nrst,
  // control side
  adcc_timer_if.timer tmr
);

  logic [10:0] cnt;
  logic        active;
  wire  [10:0] period = adcc_sample_cycles(tmr.code);
  wire         last   = active && ((cnt + 11'd1) >= period);

  // code read live so a new setting acts at once
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      active <= 1'b0;
      cnt    <= 11'h000;
    end else if (tmr.stop) begin
      active <= 1'b0;
      cnt    <= 11'h000;
    end else if (tmr.start) begin
      active <= 1'b1;
      cnt    <= 11'h000;
    end else if (last) begin
      active <= 1'b0;
    end else if (active) begin
      cnt <= cnt + 11'd1;
    end
  end

  assign tmr.active = active;
  assign tmr.done   = last && !tmr.stop;

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);

  property p_four_cycles;
    $rose(active) && tmr.code == 4'h0 |->
      (tmr.code != 4'h0 || tmr.stop || tmr.start) [*1] or
      (##3 (tmr.done || tmr.stop || tmr.start || tmr.code != 4'h0 || $past(tmr.code) != 4'h0));
  endproperty
  a_four_cycles : assert property (p_four_cycles) else $error("sample period not 4 cycles");
  property p_ceiling;
    active |-> cnt < 11'd1024;
  endproperty
  a_ceiling : assert property (p_ceiling) else $error("sample period above 1024");

endmodule

// ### adcc_timer_if.sv
`timescale 1ns/1ps
interface adcc_timer_if;
  logic       start;
  logic       stop;
  logic [3:0] code;
  logic       active;
  logic       done;
  modport ctrl  (output start, output stop, output code, input active, input done);
  modport timer (input start, input stop, input code, output active, output done);
endinterface

// ### adcc_trigger.sv
`timescale 1ns/1ps
module adcc_trigger
  import adcc_pkg::*;
(
  // clock and reset
  input  wire logic       i_clk_sys,
  input  wire logic       i_nrst,
  // trigger sources
  input  wire logic [2:0] i_timer_trig,
  input  wire logic       i_sw_start,
  input  wire logic [1:0] i_sel,
  // rising edge of the selected sample input
  output wire logic       o_edge
);

  logic [2:0] sync_a;
  logic [2:0] sync_b;
  logic       prev;

  // pins pass two flops before use
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      sync_a <= 3'h0;
      sync_b <= 3'h0;
    end else begin
      sync_a <= i_timer_trig;
      sync_b <= sync_a;
    end
  end

  wire sel_level = (i_sel == 2'b00) ? i_sw_start : sync_b[i_sel - 2'd1];

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      prev <= 1'b0;
    end else begin
      prev <= sel_level;
    end
  end

  assign o_edge = sel_level && !prev;

endmodule

// ### test_adcc_control.sv
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin error_cnt++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module test_adcc_control
  import adcc_pkg::*;
;
  logic        i_clk_sys     = 1'b0;
  logic        i_nrst        = 1'b0;
  logic [4:0]  i_addr        = 5'h00;
  logic [15:0] i_wdata       = 16'h0000;
  logic        i_wr          = 1'b0;
  logic        i_rd          = 1'b0;
  logic [2:0]  i_timer_trig  = 3'h0;
  logic        i_conv_done   = 1'b0;
  logic [9:0]  i_conv_result = 10'h000;
  wire  [15:0] o_rdata;
  wire         o_sample_hold;
  wire         o_convert_start;
  wire         o_converter_on;
  wire         o_busy;
  int          error_cnt     = 0;
  int          checks_done   = 0;
  logic [15:0] exp_q[$];
  logic [15:0] exp_v;
  logic [15:0] pop_v;
  logic        rd_d          = 1'b0;
  logic [9:0]  last_res;
  logic [4:0]  ofs[10] = '{5'h00, 5'h02, 5'h04, 5'h06, 5'h08, 5'h0a, 5'h12, 5'h1a, 5'h1c, 5'h1e};
  logic [15:0] rst[10] = '{16'h0000, 16'h0000, 16'h1000, 16'h0000, 16'hff03, 16'h0000,
                           16'h0000, 16'h0000, 16'h0000, 16'h0000};
  int          tbl[16] = '{4, 8, 16, 32, 64, 96, 128, 192, 256, 384, 512, 768,
                           1024, 1024, 1024, 1024};

  always #2.5 i_clk_sys = ~i_clk_sys;

  adcc_control dut (
    .i_clk_sys       (i_clk_sys),
    .i_nrst          (i_nrst),
    .i_addr          (i_addr),
    .i_wdata         (i_wdata),
    .i_wr            (i_wr),
    .i_rd            (i_rd),
    .o_rdata         (o_rdata),
    .i_timer_trig    (i_timer_trig),
    .i_conv_done     (i_conv_done),
    .i_conv_result   (i_conv_result),
    .o_sample_hold   (o_sample_hold),
    .o_convert_start (o_convert_start),
    .o_converter_on  (o_converter_on),
    .o_busy          (o_busy)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // read data stand only in the cycle after the strobe
  always @(posedge i_clk_sys) begin
    rd_d <= i_rd;
    if (rd_d) begin
      pop_v = (exp_q.size() > 0) ? exp_q.pop_front() : 16'hdead;
      `CHK(o_rdata, pop_v)
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic bus(input logic w, input logic r, input logic [4:0] a, input logic [15:0] d);
    i_wr <= w;
    i_rd <= r;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk_sys);
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    bus(1'b1, 1'b0, a, d);
    bus(1'b0, 1'b0, a, d);
  endtask

  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    bus(1'b0, 1'b1, a, 16'h0000);
    bus(1'b0, 1'b0, a, 16'h0000);
  endtask

  // count the hold window, then answer with a completed conversion
  task automatic finish_conv(input int exp_n);
    int n;
    n = 0;
    repeat (1100) begin
      @(negedge i_clk_sys);
      if (o_sample_hold === 1'b1) begin
        n++;
        if (n == 1) `CHK(o_busy, 1'b1)
      end else if (n > 0) begin
        break;
      end
    end
    `CHK(n, exp_n)
    `CHK(o_convert_start, 1'b1)
    last_res = 10'($urandom);
    @(posedge i_clk_sys);
    i_conv_done <= 1'b1;
    i_conv_result <= last_res;
    @(posedge i_clk_sys);
    i_conv_done <= 1'b0;
    i_conv_result <= 10'($urandom);
  endtask

  task automatic end_of_test;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (50000) @(posedge i_clk_sys);
    error_cnt++;
    end_of_test();
  end

  initial begin
    void'($urandom(32'h00a7));
    repeat (8) @(posedge i_clk_sys);
    i_nrst <= 1'b1;
    @(posedge i_clk_sys);
    for (int i = 0; i < 10; i++) rd(ofs[i], rst[i]);
    wr(5'h0c, 16'($urandom));
    rd(5'h0c, 16'h0000);
    // plain storage, write then read back to back
    for (int i = 2; i < 10; i++) begin
      exp_v = 16'($urandom);
      bus(1'b1, 1'b0, ofs[i], exp_v);
      exp_q.push_back(exp_v);
      bus(1'b0, 1'b1, ofs[i], 16'h0000);
    end
    bus(1'b0, 1'b0, 5'h00, 16'h0000);
    wr(ADCC_OFS_CTL0, 16'hf06c);
    rd(ADCC_OFS_CTL0, 16'h0000);
    wr(ADCC_OFS_CTL0, 16'hfffc);
    rd(ADCC_OFS_CTL0, 16'h0f90);
    wr(ADCC_OFS_CTL0, 16'h0312);
    wr(ADCC_OFS_CTL1, 16'h0c06);
    rd(ADCC_OFS_CTL1, 16'h0000);
    wr(ADCC_OFS_CTL0, 16'h0f92);
    rd(ADCC_OFS_CTL0, 16'h0312);
    wr(ADCC_OFS_CTL0, 16'h0010);
    rd(ADCC_OFS_CTL0, 16'h0310);
    wr(ADCC_OFS_CTL0, 16'h0003);
    rd(ADCC_OFS_CTL0, 16'h0002);
    wr(ADCC_OFS_CTL0, 16'h0000);
    wr(ADCC_OFS_CTL0, 16'h0011);
    rd(ADCC_OFS_CTL0, 16'h0010);
    `CHK(o_busy, 1'b0)
    // every sample time code, enable and start in one write
    for (int c = 0; c < 16; c++) begin
      wr(ADCC_OFS_CTL0, 16'h0010);
      wr(ADCC_OFS_CTL0, {4'h0, c[3:0], 8'h10});
      wr(ADCC_OFS_CTL0, {4'h0, c[3:0], 8'h13});
      finish_conv(tbl[c]);
      @(negedge i_clk_sys);
      `CHK(o_busy, 1'b0)
      @(posedge i_clk_sys);
      rd(ADCC_OFS_RESULT, {6'h00, last_res});
      rd(ADCC_OFS_CTL0, {4'h0, c[3:0], 8'h12});
    end
    // multi-sample in single-conversion mode has no effect
    wr(ADCC_OFS_CTL0, 16'h0010);
    wr(ADCC_OFS_CTL0, 16'h0090);
    wr(ADCC_OFS_CTL0, 16'h0093);
    finish_conv(4);
    repeat (10) @(posedge i_clk_sys);
    `CHK(o_sample_hold, 1'b0)
    `CHK(o_busy, 1'b0)
    // sequence mode restarts after each completed conversion
    wr(ADCC_OFS_CTL0, 16'h0090);
    wr(ADCC_OFS_CTL1, 16'h0002);
    wr(ADCC_OFS_CTL0, 16'h0093);
    finish_conv(4);
    finish_conv(4);
    wr(ADCC_OFS_CTL0, 16'h0090);
    wr(ADCC_OFS_CTL0, 16'h0000);
    repeat (3) @(posedge i_clk_sys);
    `CHK(o_converter_on, 1'b0)
    `CHK(o_busy, 1'b0)
    // shortening the sample time mid-sample acts at once
    wr(ADCC_OFS_CTL1, 16'h0000);
    wr(ADCC_OFS_CTL0, 16'h0f10);
    wr(ADCC_OFS_CTL0, 16'h0f13);
    repeat (20) @(posedge i_clk_sys);
    wr(ADCC_OFS_CTL0, 16'h0f10);
    wr(ADCC_OFS_CTL0, 16'h0010);
    repeat (4) @(posedge i_clk_sys);
    `CHK(o_sample_hold, 1'b0)
    i_conv_done <= 1'b1;
    @(posedge i_clk_sys);
    i_conv_done <= 1'b0;
    repeat (3) @(posedge i_clk_sys);
    `CHK(o_busy, 1'b0)
    // timer trigger sources
    for (int s = 1; s < 4; s++) begin
      wr(ADCC_OFS_CTL0, 16'h0010);
      wr(ADCC_OFS_CTL1, {4'h0, s[1:0], 10'h000});
      wr(ADCC_OFS_CTL0, 16'h0012);
      i_timer_trig <= 3'(1 << (s % 3));
      repeat (6) @(posedge i_clk_sys);
      i_timer_trig <= 3'h0;
      repeat (6) @(posedge i_clk_sys);
      `CHK(o_busy, 1'b0)
      wr(ADCC_OFS_CTL0, 16'h0013);
      `CHK(o_busy, 1'b0)
      i_timer_trig <= 3'(1 << (s - 1));
      finish_conv(4);
      i_timer_trig <= 3'h0;
    end
    wr(ADCC_OFS_CTL0, 16'h0010);
    wr(ADCC_OFS_CTL1, 16'h0000);
    repeat (4) @(posedge i_clk_sys);
    end_of_test();
  end
endmodule
